/* File: include/pbm_pkg.sv */
package pbm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_OUTPUT = 8'h00;
    localparam logic [7:0] OFS_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_PIN_INPUT = 8'h08;
    localparam logic [7:0] OFS_SPECIAL_FUNCTION_IO_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_PERIPHERAL_MODE = 8'h10;
    // field positions
    localparam int BIT_GLOBAL_PULLUP_DISABLE = 2;
    localparam int BIT_SERIAL_PERIPHERAL_ENABLE = 0;
    localparam int BIT_SERIAL_MASTER_SELECT = 1;
    localparam int BIT_TIMER2_ASYNC_CLOCK_SELECT = 3;
    // pin positions
    localparam int PIN_CAPTURE = 0;
    localparam int PIN_CMP_A = 1;
    localparam int PIN_SELECT = 2;
    localparam int PIN_MOSI = 3;
    localparam int PIN_MISO = 4;
    localparam int PIN_SCK = 5;
    localparam int PIN_OSC_IN = 6;
    localparam int PIN_OSC_OUT = 7;
    // reset values
    localparam logic [7:0] RST_OUTPUT = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_SPECIAL_FUNCTION_IO_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_MODE = 8'h00;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pbm_pkg

/* File: rtl/pbm_port_b_mux.sv */
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// R01: global pull-up disable set turns off every pull-up, whatever direction and output bits say.
// R02: default pull-up only when direction zero, output bit one, pull-up disable zero.
// R03: each asserted override enable replaces its register-derived setting with the override value.
// R04: pins 7,6 are timer oscillator only with internal RC clock and async timer-2 bit; the code takes both on the async bit under any chip clock.
// R05: async timer-2 clocking detaches pin 7 as oscillator amplifier output.
// R06: async timer-2 clocking detaches pin 6 as oscillator amplifier input.
// R07: pin 6 is clock pin for any chip clock other than internal RC.
// R08: clock-used pins 7/6 read zero in direction, output and pin input bits.
// R09: serial slave forces pin 5 input; master leaves it to its direction bit.
// R10: serial master forces pin 4 input; slave leaves it to its direction bit.
// R11: serial slave forces pin 3 input; master leaves it to its direction bit.
// R12: serial slave forces pin 2 input; slave active only while pin 2 low.
// R13: pins forced to input keep pull-up from output bit, subject to global disable.
// R14: pin 4 is master receive and slave transmit; pin 3 the reverse.
// R15: pin 3 value is OR of serial master output and timer-2 compare output.
// R16: software sets pin 3 direction to output for timer-2 compare waveform.
// R17: software sets pin 2 direction to output; timer supplies compare-B value.
// R18: software sets pin 1 direction to output; timer supplies compare-A value.
// R19: pin 0 feeds capture input; no pull-up, direction or output override there.
// R20: oscillator-taken pins 6/7 have digital input enable overridden to disabled.
module pbm_port_b_mux
    import pbm_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // clock source fuses
    input wire logic internal_rc_selected,
    input wire logic external_clock_selected,
    // pads
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pad_pullup_en,
    output logic [PINS-1:0] pad_input_en,
    // peripheral outputs towards the pins
    input wire logic spi_sck_out,
    input wire logic spi_master_out,
    input wire logic spi_slave_out,
    input wire logic timer2_compare_output,
    input wire logic timer2_compare_enable,
    input wire logic timer1_compare_a_output,
    input wire logic timer1_compare_a_enable,
    input wire logic timer1_compare_b_output,
    input wire logic timer1_compare_b_enable,
    // pin inputs and register mode bits towards the peripherals
    output logic spi_sck_in,
    output logic spi_master_in,
    output logic spi_slave_in,
    output logic spi_select_n,
    output logic timer1_capture_input,
    output logic serial_peripheral_enable,
    output logic serial_master_select,
    output logic timer2_async_clock_select
);
    logic [7:0] pin_output_bit_q, pin_direction_bit_q, sfio_ctrl_q, periph_mode_q, pin_input_q;
    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic global_pullup_disable, serial_en, serial_master, t2_async;
    logic slave_mode, master_mode, osc6_taken, osc7_taken;
    logic [7:0] clock_pin;
    logic [7:0] pullup_override_enable, pullup_override_value;
    logic [7:0] direction_override_enable, direction_override_value;
    logic [7:0] output_value_override_enable, output_value_override_value;
    logic [7:0] input_enable_override_enable, input_enable_override_value;
    logic [7:0] pullup_d, oe_d, out_d, ie_d, rd_byte;
    logic rd_hit, wr_hit, do_write;

    assign global_pullup_disable = sfio_ctrl_q[BIT_GLOBAL_PULLUP_DISABLE];
    assign serial_en = periph_mode_q[BIT_SERIAL_PERIPHERAL_ENABLE];
    assign serial_master = periph_mode_q[BIT_SERIAL_MASTER_SELECT];
    assign t2_async = periph_mode_q[BIT_TIMER2_ASYNC_CLOCK_SELECT];
    assign slave_mode = serial_en & ~serial_master;
    assign master_mode = serial_en & serial_master;

    // the timer oscillator owns both pins whenever the async bit is set, under any chip clock
    assign osc6_taken = ~internal_rc_selected | t2_async; // [R04] [R06] [R07]
    // an external clock leaves the amplifier output free for general use
    assign osc7_taken = (~internal_rc_selected & ~external_clock_selected) | t2_async; // [R04] [R05]
    assign clock_pin = {osc7_taken, osc6_taken, 6'h00};

    always_comb begin
        pullup_override_enable = 8'h00;
        pullup_override_value = 8'h00;
        direction_override_enable = 8'h00;
        direction_override_value = 8'h00;
        output_value_override_enable = 8'h00;
        output_value_override_value = 8'h00;
        input_enable_override_enable = 8'h00;
        input_enable_override_value = 8'h00;
        // oscillator pins: no pull-up, no driver, no digital input
        pullup_override_enable[PIN_OSC_OUT] = osc7_taken; // [R05]
        direction_override_enable[PIN_OSC_OUT] = osc7_taken; // [R05]
        input_enable_override_enable[PIN_OSC_OUT] = osc7_taken; // [R20]
        pullup_override_enable[PIN_OSC_IN] = osc6_taken; // [R06] [R07]
        direction_override_enable[PIN_OSC_IN] = osc6_taken; // [R06] [R07]
        input_enable_override_enable[PIN_OSC_IN] = osc6_taken; // [R20]
        // serial clock: input as slave, driven by the master clock as master
        pullup_override_enable[PIN_SCK] = slave_mode; // [R09]
        direction_override_enable[PIN_SCK] = slave_mode; // [R09]
        output_value_override_enable[PIN_SCK] = master_mode;
        output_value_override_value[PIN_SCK] = spi_sck_out;
        // master in / slave out
        pullup_override_enable[PIN_MISO] = master_mode; // [R10]
        direction_override_enable[PIN_MISO] = master_mode; // [R10]
        output_value_override_enable[PIN_MISO] = slave_mode; // [R14]
        output_value_override_value[PIN_MISO] = spi_slave_out; // [R14]
        // master out / slave in, shared with the timer-2 compare
        pullup_override_enable[PIN_MOSI] = slave_mode; // [R11]
        direction_override_enable[PIN_MOSI] = slave_mode; // [R11]
        output_value_override_enable[PIN_MOSI] = master_mode | timer2_compare_enable; // [R15] [R16]
        output_value_override_value[PIN_MOSI] = (master_mode & spi_master_out)
            | (timer2_compare_enable & timer2_compare_output); // [R15] [R14]
        // slave select, shared with timer-1 compare b
        pullup_override_enable[PIN_SELECT] = slave_mode; // [R12]
        direction_override_enable[PIN_SELECT] = slave_mode; // [R12]
        output_value_override_enable[PIN_SELECT] = timer1_compare_b_enable; // [R17]
        output_value_override_value[PIN_SELECT] = timer1_compare_b_output; // [R17]
        output_value_override_enable[PIN_CMP_A] = timer1_compare_a_enable; // [R18]
        output_value_override_value[PIN_CMP_A] = timer1_compare_a_output; // [R18]
        // forced inputs keep the output-bit pull-up, still under global disable
        pullup_override_value[PIN_SCK] = pin_output_bit_q[PIN_SCK] & ~global_pullup_disable; // [R13]
        pullup_override_value[PIN_MISO] = pin_output_bit_q[PIN_MISO] & ~global_pullup_disable; // [R13]
        pullup_override_value[PIN_MOSI] = pin_output_bit_q[PIN_MOSI] & ~global_pullup_disable; // [R13]
        pullup_override_value[PIN_SELECT] = pin_output_bit_q[PIN_SELECT] & ~global_pullup_disable; // [R13]
        // capture pin keeps every override clear [R19]
    end

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_comb begin
            pullup_d[i] = pullup_override_enable[i] ? pullup_override_value[i]
                : (~pin_direction_bit_q[i] & pin_output_bit_q[i] & ~global_pullup_disable); // [R01] [R02] [R03]
            oe_d[i] = direction_override_enable[i] ? direction_override_value[i]
                : pin_direction_bit_q[i]; // [R03]
            out_d[i] = output_value_override_enable[i] ? output_value_override_value[i]
                : pin_output_bit_q[i]; // [R03]
            ie_d[i] = input_enable_override_enable[i] ? input_enable_override_value[i] : 1'b1; // [R03]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_pullup_en <= 8'h00;
            pad_oe <= 8'h00;
            pad_out <= 8'h00;
            pad_input_en <= 8'h00;
        end else begin
            pad_pullup_en <= pullup_d;
            pad_oe <= oe_d;
            pad_out <= out_d;
            pad_input_en <= ie_d;
        end
    end

    // disabled inputs are clamped low before sampling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_input_q <= 8'h00;
            spi_sck_in <= 1'b0;
            spi_master_in <= 1'b0;
            spi_slave_in <= 1'b0;
            spi_select_n <= 1'b1;
            timer1_capture_input <= 1'b0;
        end else begin
            pin_input_q <= pad_in & ie_d;
            spi_sck_in <= pad_in[PIN_SCK];
            spi_master_in <= pad_in[PIN_MISO]; // [R14]
            spi_slave_in <= pad_in[PIN_MOSI]; // [R14]
            spi_select_n <= slave_mode ? pad_in[PIN_SELECT] : 1'b1; // [R12]
            timer1_capture_input <= pad_in[PIN_CAPTURE]; // [R19]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_peripheral_enable <= 1'b0;
            serial_master_select <= 1'b0;
            timer2_async_clock_select <= 1'b0;
        end else begin
            serial_peripheral_enable <= serial_en;
            serial_master_select <= serial_master;
            timer2_async_clock_select <= t2_async;
        end
    end

    // write channel: address and data are latched independently
    assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_hit = (awaddr_q == OFS_OUTPUT) || (awaddr_q == OFS_DIRECTION)
        || (awaddr_q == OFS_PIN_INPUT) || (awaddr_q == OFS_SPECIAL_FUNCTION_IO_CONTROL)
        || (awaddr_q == OFS_PERIPHERAL_MODE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    // only byte lane 0 carries the 8-bit registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_output_bit_q <= RST_OUTPUT;
            pin_direction_bit_q <= RST_DIRECTION;
            sfio_ctrl_q <= RST_SPECIAL_FUNCTION_IO_CONTROL;
            periph_mode_q <= RST_PERIPHERAL_MODE;
        end else if (do_write && wstrb_q[0]) begin
            case (awaddr_q)
                OFS_OUTPUT: pin_output_bit_q <= wdata_q[7:0];
                OFS_DIRECTION: pin_direction_bit_q <= wdata_q[7:0];
                OFS_SPECIAL_FUNCTION_IO_CONTROL: sfio_ctrl_q <= wdata_q[7:0]; // [R01]
                OFS_PERIPHERAL_MODE: periph_mode_q <= wdata_q[7:0];
                default: ;
            endcase
        end
    end

    // clock-used pins hide their bits from software
    always_comb begin
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            OFS_OUTPUT: rd_byte = pin_output_bit_q & ~clock_pin; // [R08]
            OFS_DIRECTION: rd_byte = pin_direction_bit_q & ~clock_pin; // [R08]
            OFS_PIN_INPUT: rd_byte = pin_input_q & ~clock_pin; // [R08]
            OFS_SPECIAL_FUNCTION_IO_CONTROL: rd_byte = sfio_ctrl_q;
            OFS_PERIPHERAL_MODE: rd_byte = periph_mode_q;
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PULLUP_OFF: assert property ($past(global_pullup_disable) && !$past(slave_mode) && !$past(master_mode)
        |-> pad_pullup_en == 8'h00) else $error("pull-up on while disabled"); // [R01]
    AST_DEFAULT_PULLUP: assert property ($past(pullup_override_enable[1]) == 1'b0
        |-> pad_pullup_en[1] == ($past(pin_output_bit_q[1]) & ~$past(pin_direction_bit_q[1])
        & ~$past(global_pullup_disable))) else $error("default pull-up wrong"); // [R02]
    AST_OSC7_DETACH: assert property ($past(osc7_taken) |-> !pad_oe[7] && !pad_pullup_en[7] && !pad_input_en[7])
        else $error("pin 7 not detached"); // [R05]
    AST_OSC6_DETACH: assert property ($past(osc6_taken) |-> !pad_oe[6] && !pad_pullup_en[6] && !pad_input_en[6])
        else $error("pin 6 not detached"); // [R06]
    AST_CLOCK_PIN_READ: assert property (s_axi_arvalid && s_axi_arready && osc6_taken
        && (s_axi_araddr == OFS_DIRECTION) |=> !s_axi_rdata[6]) else $error("clock pin read nonzero"); // [R08]
    AST_SLAVE_INPUTS: assert property ($past(slave_mode) |-> !pad_oe[PIN_SCK] && !pad_oe[PIN_MOSI]
        && !pad_oe[PIN_SELECT]) else $error("slave pin driven"); // [R09]
    AST_MASTER_MISO: assert property ($past(master_mode) |-> !pad_oe[PIN_MISO])
        else $error("miso driven as master"); // [R10]
    AST_MOSI_OR: assert property ($past(master_mode) && $past(timer2_compare_enable)
        |-> pad_out[PIN_MOSI] == ($past(spi_master_out) | $past(timer2_compare_output)))
        else $error("mosi value wrong"); // [R15]
    AST_SELECT: assert property (!slave_mode ##1 !slave_mode |-> spi_select_n)
        else $error("select active outside slave"); // [R12]
    AST_CAPTURE: assert property (##1 timer1_capture_input == $past(pad_in[PIN_CAPTURE])
        && pad_oe[0] == $past(pin_direction_bit_q[0])) else $error("capture pin wrong"); // [R19]
    AST_BRESP_WAIT: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");

    COV_SLAVE: cover property (slave_mode ##1 !spi_select_n);
    COV_MASTER_OC2: cover property (master_mode && timer2_compare_enable);
    COV_ASYNC: cover property (t2_async && internal_rc_selected);
endmodule : pbm_port_b_mux

/* File: bench/pbm_periph_model.sv */
`timescale 1ns/10ps
module pbm_periph_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request for a fresh set of levels
    input wire logic step,
    // sck, master out, slave out, t2 value/enable, t1a value/enable, t1b value/enable
    output logic [8:0] lvl
);
    // levels move only on request so that the bench can predict every pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl <= 9'h000;
        end else if (step) begin
            lvl <= 9'($urandom);
        end
    end
endmodule : pbm_periph_model

/* File: bench/tb_port_b_alternate_function_mux.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module tb_port_b_alternate_function_mux;
    import pbm_pkg::*;
    typedef struct packed {logic [7:0] oe, out, pu, ie;} pbm_exp_t;
    logic aclk = 1'b0, aresetn = 1'b0, step = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic internal_rc_selected = 1'b1, external_clock_selected = 1'b0;
    logic [7:0] pad_in = 8'h00, pad_out, pad_oe, pad_pullup_en, pad_input_en, o_r, d_r, s_r, m_r, tk;
    logic [8:0] lvl;
    logic spi_sck_in, spi_master_in, spi_slave_in, spi_select_n, timer1_capture_input;
    logic serial_peripheral_enable, serial_master_select, timer2_async_clock_select;
    int error_cnt = 0, samples_checked = 0;
    pbm_exp_t ex;

    pbm_port_b_mux u_pbm_port_b_mux (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .internal_rc_selected, .external_clock_selected, .pad_in, .pad_out, .pad_oe, .pad_pullup_en,
        .pad_input_en, .spi_sck_out(lvl[0]), .spi_master_out(lvl[1]), .spi_slave_out(lvl[2]),
        .timer2_compare_output(lvl[3]), .timer2_compare_enable(lvl[4]), .timer1_compare_a_output(lvl[5]),
        .timer1_compare_a_enable(lvl[6]), .timer1_compare_b_output(lvl[7]), .timer1_compare_b_enable(lvl[8]),
        .spi_sck_in, .spi_master_in, .spi_slave_in, .spi_select_n, .timer1_capture_input, .serial_peripheral_enable,
        .serial_master_select, .timer2_async_clock_select);
    pbm_periph_model u_pbm_periph_model (.aclk, .aresetn, .step, .lvl);

    initial begin
        forever #4 aclk = ~aclk;
    end

    task automatic give_verdict;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic timeout;
        error_cnt++;
        $display("ERROR %0t handshake timeout", $time);
        give_verdict();
    endtask : timeout

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 64) timeout();
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 64) timeout();
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        `CHK({rd, rsp}, {ed, er})
        @(posedge aclk);
    endtask : chk_rd

    // predicted pin controls from the programmed registers, fuses and peripheral levels
    function automatic pbm_exp_t calc();
        pbm_exp_t e;
        logic sl, ms;
        logic [7:0] frc;
        sl = m_r[0] & !m_r[1];
        ms = m_r[0] & m_r[1];
        tk = {(!internal_rc_selected & !external_clock_selected) | m_r[3], !internal_rc_selected | m_r[3], 6'h00};
        frc = {2'b00, sl, ms, sl, sl, 2'b00};
        e.oe = d_r & ~frc & ~tk;
        e.pu = o_r & ~e.oe & ~tk & {8{!s_r[2]}};
        e.ie = ~tk;
        e.out = o_r;
        if (ms) e.out[5] = lvl[0];
        if (sl) e.out[4] = lvl[2];
        if (ms | lvl[4]) e.out[3] = (ms & lvl[1]) | (lvl[4] & lvl[3]);
        if (lvl[6]) e.out[1] = lvl[5];
        if (lvl[8]) e.out[2] = lvl[7];
        return e;
    endfunction : calc

    initial begin
        int i;
        void'($urandom(32'h9c742056));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 5; i++) chk_rd(8'(i * 4), 32'h0, RESP_OKAY);
        chk_rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 8'hff, 4'hf);
        `CHK(rsp, RESP_SLVERR)
        wr(OFS_PIN_INPUT, 8'hff, 4'hf);
        `CHK(rsp, RESP_OKAY)
        wr(OFS_OUTPUT, 8'hff, 4'h0);
        `CHK(rsp, RESP_OKAY)
        chk_rd(OFS_OUTPUT, 32'h0, RESP_OKAY);
        for (i = 0; i < 60; i++) begin
            o_r = 8'($urandom);
            d_r = 8'($urandom);
            s_r = 8'($urandom);
            m_r = 8'($urandom) & 8'h0b;
            if (i < 4) begin
                // global pull-up disable, then pull-ups armed everywhere, then slave and master with every pin set to output
                o_r = 8'hff;
                d_r = (i < 2) ? 8'h00 : 8'hff;
                s_r = {5'h00, i == 0, 2'b00};
                m_r = {6'h00, i == 3, i >= 2};
            end
            internal_rc_selected <= (i < 4) ? 1'b1 : 1'($urandom);
            external_clock_selected <= (i < 4) ? 1'b0 : 1'($urandom);
            pad_in <= 8'($urandom);
            step <= 1'b1;
            @(posedge aclk);
            step <= 1'b0;
            wr(OFS_OUTPUT, o_r, 4'hf);
            wr(OFS_DIRECTION, d_r, 4'hf);
            wr(OFS_SPECIAL_FUNCTION_IO_CONTROL, s_r, 4'hf);
            wr(OFS_PERIPHERAL_MODE, m_r, 4'hf);
            repeat (3) @(posedge aclk);
            ex = calc();
            `CHK(pad_oe, ex.oe)
            `CHK(pad_pullup_en, ex.pu)
            `CHK(pad_input_en, ex.ie)
            `CHK(pad_out, ex.out)
            `CHK({spi_sck_in, spi_master_in, spi_slave_in, timer1_capture_input}, {pad_in[5:3], pad_in[0]})
            `CHK(spi_select_n, (m_r[0] & !m_r[1]) ? pad_in[2] : 1'b1)
            `CHK({timer2_async_clock_select, serial_master_select, serial_peripheral_enable}, {m_r[3], m_r[1:0]})
            chk_rd(OFS_OUTPUT, {24'h0, o_r & ~tk}, RESP_OKAY);
            chk_rd(OFS_DIRECTION, {24'h0, d_r & ~tk}, RESP_OKAY);
            chk_rd(OFS_PIN_INPUT, {24'h0, pad_in & ~tk}, RESP_OKAY);
            chk_rd(OFS_SPECIAL_FUNCTION_IO_CONTROL, {24'h0, s_r}, RESP_OKAY);
            chk_rd(OFS_PERIPHERAL_MODE, {24'h0, m_r}, RESP_OKAY);
        end
        give_verdict();
    end
endmodule : tb_port_b_alternate_function_mux
